// >>> core/spwm_actuator.v
// shifted pwm actuator: compensation, modulation, edge shifting, startup
`timescale 1ns/10ps
`include "spwm_regs.vh"
module spwm_actuator #(
	parameter W       = 16,
	parameter MIN_WIN = 16'h0040,
	parameter LOW_MOD = 16'h0100,
	parameter PERIOD  = 16'h0800
) (
	input  wire                ref_clk_i,
	input  wire                nrst_i,
	input  wire                fast_loop_tick_i,
	input  wire [2:0]          motor_state_i,
	input  wire signed [W-1:0] u_alpha_i,
	input  wire signed [W-1:0] u_beta_i,
	input  wire [W-1:0]        bus_voltage_i,
	input  wire signed [W-1:0] i_alpha_i,
	input  wire signed [W-1:0] i_beta_i,
	input  wire                overcurrent_comparator_i,
	output reg  [W-1:0]        duty_a_o,
	output reg  [W-1:0]        duty_b_o,
	output reg  [W-1:0]        duty_c_o,
	output reg  signed [W-1:0] shift_a_o,
	output reg  signed [W-1:0] shift_b_o,
	output reg  signed [W-1:0] shift_c_o,
	output reg  [W-1:0]        sample1_o,
	output reg  [W-1:0]        sample2_o,
	output reg                 table_update_o,
	output reg  [1:0]          method_o,
	output reg                 pwm_enable_o,
	output reg                 fault_auto_clear_o,
	output reg                 pwm_outputs_off_o,
	output reg                 boot_done_o
);
	reg rst_s1;
	reg rst_s2;
	wire rst_n = rst_s2;

	// reset release through two flops
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	// run states decode, used once for the run flag
	function run_state;
		input [2:0] s;
		begin
			run_state = (s == `SPWM_ST_ALIGN) || (s == `SPWM_ST_LOW) ||
				(s == `SPWM_ST_MID) || (s == `SPWM_ST_HIGH);
		end
	endfunction

	// inverter error voltage lookup by current magnitude
	function signed [W-1:0] dt_lut;
		input signed [W-1:0] cur;
		reg [W-1:0] mag;
		reg [`SPWM_LUT_BITS-1:0] idx;
		reg [W-1:0] v;
		begin
			mag = cur[W-1] ? (~cur + 1'b1) : cur;
			idx = mag[W-2 -: `SPWM_LUT_BITS];
			case (idx)
				4'h0: v = 16'h0010;
				4'h1: v = 16'h0030;
				4'h2: v = 16'h0048;
				4'h3: v = 16'h0058;
				4'h4: v = 16'h0060;
				default: v = 16'h0064;
			endcase
			dt_lut = cur[W-1] ? -$signed(v) : $signed(v);
		end
	endfunction

	wire run = run_state(motor_state_i);
	wire tick_run = fast_loop_tick_i && run;

	// dead-time compensation in the stationary frame
	wire signed [W-1:0] ua_dt = u_alpha_i + dt_lut(i_alpha_i);
	wire signed [W-1:0] ub_dt = u_beta_i + dt_lut(i_beta_i);

	// bus ripple compensation: scale by nominal over measured
	wire [W-1:0] bus_safe = (bus_voltage_i == {W{1'b0}}) ? 16'h0001 : bus_voltage_i;
	wire signed [2*W-1:0] ua_w = (ua_dt * $signed({1'b0, `SPWM_BUS_NOM})) /
		$signed({1'b0, bus_safe});
	wire signed [2*W-1:0] ub_w = (ub_dt * $signed({1'b0, `SPWM_BUS_NOM})) /
		$signed({1'b0, bus_safe});
	wire signed [W-1:0] ua = ua_w[W-1:0];
	wire signed [W-1:0] ub = ub_w[W-1:0];

	// phase voltages by inverse clarke (beta*sqrt3/2 ~ 0.866)
	wire signed [2*W-1:0] kb = ub * 16'sh376d;
	wire signed [W-1:0] ub3 = kb[2*W-3 -: W]; // coefficient is scaled by 2^14
	wire signed [W-1:0] va = ua;
	wire signed [W-1:0] vb = -(ua >>> 1) + ub3;
	wire signed [W-1:0] vc = -(ua >>> 1) - ub3;

	// centred duties, half period plus phase voltage
	wire [W-1:0] half = PERIOD >> 1;
	wire [W-1:0] da = half + va;
	wire [W-1:0] db = half + vb;
	wire [W-1:0] dc = half + vc;

	// sort duties to find max, mid, min phases
	wire [W-1:0] dmax = (da > db) ? ((da > dc) ? da : dc) : ((db > dc) ? db : dc);
	wire [W-1:0] dmin = (da < db) ? ((da < dc) ? da : dc) : ((db < dc) ? db : dc);
	wire [W-1:0] dmid = da + db + dc - dmax - dmin;
	wire [W-1:0] win1 = dmax - dmid;
	wire [W-1:0] win2 = dmid - dmin;
	wire low_mod = (win1 < LOW_MOD) && (win2 < LOW_MOD);
	wire border = !low_mod && ((win1 < MIN_WIN) || (win2 < MIN_WIN));

	reg [1:0] next_method;
	reg signed [W-1:0] next_sa;
	reg signed [W-1:0] next_sb;
	reg signed [W-1:0] next_sc;

	// method choice and per-phase shifts; shifts move edges, not widths
	always @* begin
		next_method = `SPWM_MTH_NONE;
		next_sa = {W{1'b0}};
		next_sb = {W{1'b0}};
		next_sc = {W{1'b0}};
		if (low_mod) begin
			next_method = `SPWM_MTH_BOTH;
			// mid phase frozen, max and min pushed opposite ways
			if (da == dmax) next_sa = MIN_WIN;
			else if (da == dmin) next_sa = -$signed(MIN_WIN);
			if (db == dmax && da != dmax) next_sb = MIN_WIN;
			else if (db == dmin && da != dmin) next_sb = -$signed(MIN_WIN);
			if (dc == dmax && da != dmax && db != dmax) next_sc = MIN_WIN;
			else if (dc == dmin && da != dmin && db != dmin) next_sc = -$signed(MIN_WIN);
		end else if (border) begin
			next_method = `SPWM_MTH_ONE;
			// only the critical edge moves, centre stays
			if (win1 < MIN_WIN) begin
				if (da == dmax) next_sa = MIN_WIN - win1;
				else if (db == dmax) next_sb = MIN_WIN - win1;
				else next_sc = MIN_WIN - win1;
			end else begin
				if (da == dmin) next_sa = -$signed(MIN_WIN - win2);
				else if (db == dmin) next_sb = -$signed(MIN_WIN - win2);
				else next_sc = -$signed(MIN_WIN - win2);
			end
		end
	end

	reg [15:0] boot_cnt;
	reg        booting;

	// outputs update on run ticks; duties never altered by shifts
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			duty_a_o <= {W{1'b0}};
			duty_b_o <= {W{1'b0}};
			duty_c_o <= {W{1'b0}};
			shift_a_o <= {W{1'b0}};
			shift_b_o <= {W{1'b0}};
			shift_c_o <= {W{1'b0}};
			sample1_o <= {W{1'b0}};
			sample2_o <= {W{1'b0}};
			method_o <= `SPWM_MTH_NONE;
			table_update_o <= 1'b0;
		end else begin
			table_update_o <= tick_run;
			if (tick_run) begin
				duty_a_o <= da;
				duty_b_o <= db;
				duty_c_o <= dc;
				shift_a_o <= next_sa;
				shift_b_o <= next_sb;
				shift_c_o <= next_sc;
				method_o <= next_method;
				// sample instants inside the two active windows
				sample1_o <= half - (dmid >> 1) - (MIN_WIN >> 1);
				sample2_o <= half - (dmin >> 1) - (MIN_WIN >> 1);
			end
		end
	end

	// bootstrap startup, fault clearing mode and output gating
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			boot_cnt <= 16'h0000;
			booting <= 1'b0;
			boot_done_o <= 1'b0;
			pwm_enable_o <= 1'b0;
			fault_auto_clear_o <= 1'b0;
			pwm_outputs_off_o <= 1'b1;
		end else if (motor_state_i == `SPWM_ST_STOP) begin
			boot_cnt <= 16'h0000;
			booting <= 1'b0;
			boot_done_o <= 1'b0;
			pwm_enable_o <= 1'b0;
			fault_auto_clear_o <= 1'b0;
			pwm_outputs_off_o <= 1'b1;
		end else if (motor_state_i == `SPWM_ST_ALIGN && !boot_done_o && !booting &&
			fast_loop_tick_i) begin
			booting <= 1'b1;
			boot_cnt <= 16'h0000;
			pwm_enable_o <= 1'b1;
			fault_auto_clear_o <= 1'b1;
			pwm_outputs_off_o <= overcurrent_comparator_i;
		end else if (booting) begin
			// comparator cuts outputs, auto clear resumes them
			pwm_outputs_off_o <= overcurrent_comparator_i;
			if (fast_loop_tick_i) begin
				if (boot_cnt == `SPWM_BOOT_TICKS - 16'h0001) begin
					booting <= 1'b0;
					boot_done_o <= 1'b1;
					fault_auto_clear_o <= 1'b0;
				end else begin
					boot_cnt <= boot_cnt + 16'h0001;
				end
			end
		end else if (boot_done_o) begin
			// latched: an over-current keeps outputs off until stop
			if (overcurrent_comparator_i)
				pwm_outputs_off_o <= 1'b1;
		end
	end
endmodule

// >>> core/spwm_regs.vh
// constants for the shifted pwm actuator
// Behaviour
// - edge shifts preserve every phase duty
// - detect sector boundary allowing one sample
// - detect low modulation index, no samples
// - boundary case: freeze centre, move critical edge
// - low index: move both side edges oppositely
// - choose method, output shifts and sample instants
// - run each fast tick in run states
// - scale voltage request by bus voltage
// - add lookup error voltage by phase current
// - bootstrap charging at start of align
// - automatic fault clearing during startup
// - outputs disabled while stopped
`ifndef SPWM_REGS_VH
`define SPWM_REGS_VH
`define SPWM_ST_STOP     3'h0
`define SPWM_ST_ALIGN    3'h1
`define SPWM_ST_LOW      3'h2
`define SPWM_ST_MID      3'h3
`define SPWM_ST_HIGH     3'h4
`define SPWM_MTH_NONE    2'h0
`define SPWM_MTH_ONE     2'h1
`define SPWM_MTH_BOTH    2'h2
`define SPWM_BOOT_TICKS  16'h0010
`define SPWM_LUT_BITS    4
`define SPWM_BUS_NOM     16'h4000
`endif

// >>> verif/shifted_pwm_actuator_tb_top.sv
// self-checking bench for the actuator
`timescale 1ns/10ps
`include "spwm_regs.vh"
module shifted_pwm_actuator_tb_top;
	logic               clk = 0, nrst = 0, tick = 0, spike = 0, oc, upd, en, auto, off, done;
	logic [2:0]         st = 3'h0;
	logic signed [15:0] ua = 0, ub = 0, ia = 0, ib = 0;
	logic [15:0]        bus = `SPWM_BUS_NOM, da, db, dc, sa, sb, sc, sp, s1, s2;
	logic [1:0]         mth;
	int                 errors = 0, checks = 0;
	spwm_actuator i_spwm_actuator (.ref_clk_i(clk), .nrst_i(nrst), .fast_loop_tick_i(tick),
		.motor_state_i(st), .u_alpha_i(ua), .u_beta_i(ub), .bus_voltage_i(bus), .i_alpha_i(ia),
		.i_beta_i(ib), .overcurrent_comparator_i(oc), .duty_a_o(da), .duty_b_o(db), .duty_c_o(dc),
		.shift_a_o(sa), .shift_b_o(sb), .shift_c_o(sc), .sample1_o(s1), .sample2_o(s2),
		.table_update_o(upd), .method_o(mth), .pwm_enable_o(en), .fault_auto_clear_o(auto),
		.pwm_outputs_off_o(off), .boot_done_o(done));
	spwm_ipm_model i_spwm_ipm_model (.spike_i(spike), .outputs_off_i(off), .oc_o(oc));
	always #12.5 clk = ~clk;
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		checks++;
		if (got !== ex) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, ex, got);
		end
	endtask
	// one tick, checked once the answer has landed
	task automatic step(input logic [2:0] s);
		st = s;
		tick = 1;
		@(posedge clk) #1;
		tick = 0;
		chk("update", {15'h0, s != 0 && s < 5}, upd);
		@(posedge clk) #1;
	endtask
	task automatic t_stop();
		step(`SPWM_ST_STOP);
		chk("off", 1, off);
		step(3'h5);
	endtask
	// bootstrap charging rides through spikes
	task automatic t_boot();
		step(`SPWM_ST_ALIGN);
		chk("auto", 1, auto);
		for (int i = 1; i <= 16; i++) begin
			chk("done", 0, done);
			spike = i < 3;
			step(`SPWM_ST_ALIGN);
		end
		chk("done", 1, done);
		chk("off", 0, off);
	endtask
	task automatic t_modes();
		step(`SPWM_ST_LOW);
		chk("low", `SPWM_MTH_BOTH, mth);
		chk("centre", 16'h0000, sb);
		chk("side max", 16'h0040, sa);
		chk("side min", 16'hffc0, sc);
		ua = 16'sh0200;
		step(`SPWM_ST_MID);
		chk("border", `SPWM_MTH_ONE, mth);
		chk("fixed a", 16'h0000, sa);
		chk("fixed b", 16'h0000, sb);
		chk("critical", 16'hffda, sc);
		ub = 16'sh0100;
		step(`SPWM_ST_HIGH);
		chk("clear", `SPWM_MTH_NONE, mth);
		chk("no shift", 16'h0000, sa | sb | sc);
		chk("window1", 1, {15'h0, s1 >= 16'h0400 - (da >> 1) && s1 <= 16'h0400 - (db >> 1)});
		chk("window2", 1, {15'h0, s2 >= 16'h0400 - (db >> 1) && s2 <= 16'h0400 - (dc >> 1)});
		sp = da - dc;
		bus = 16'h2000;
		step(`SPWM_ST_HIGH);
		chk("ripple", 1, {15'h0, (da - dc) > sp});
		sp = da;
		ia = 16'sh2000;
		step(`SPWM_ST_HIGH);
		chk("deadtime", 1, {15'h0, da !== sp});
	endtask
	// latched cutoff after charging; stop clears enable and done, outputs stay off
	task automatic t_latch();
		spike = 1;
		step(`SPWM_ST_MID);
		spike = 0;
		step(`SPWM_ST_MID);
		chk("latch", 1, off);
		step(`SPWM_ST_STOP);
		chk("stopped", 0, {14'h0, en, done});
	endtask
	task automatic wrap_up();
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1 nrst = 1;
		repeat (3) @(posedge clk);
		#1;
		t_stop();
		t_boot();
		t_modes();
		t_latch();
		wrap_up();
	end
	initial begin
		#20000;
		errors++;
		wrap_up();
	end
endmodule

// >>> verif/spwm_ipm_model.sv
// shunt over-current comparator of the power module
`timescale 1ns/10ps
module spwm_ipm_model (
	input  wire logic spike_i,
	input  wire logic outputs_off_i,
	output wire logic oc_o
);
	// spikes reach the shunt only while the bridge conducts
	assign oc_o = spike_i && !outputs_off_i;
endmodule

// >>> verif/spwm_props.sv
// assertions on the actuator ports
`timescale 1ns/10ps
`include "spwm_regs.vh"
module spwm_props (
	input wire logic        ref_clk_i,
	input wire logic        nrst_i,
	input wire logic        fast_loop_tick_i,
	input wire logic [2:0]  motor_state_i,
	input wire logic        overcurrent_comparator_i,
	input wire logic [15:0] duty_a_o,
	input wire logic        table_update_o,
	input wire logic        pwm_enable_o,
	input wire logic        fault_auto_clear_o,
	input wire logic        pwm_outputs_off_o,
	input wire logic        boot_done_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// tick taken in a run state
	wire run = fast_loop_tick_i && motor_state_i != 3'h0 && motor_state_i < 3'h5;
	sequence boot_run;
		fault_auto_clear_o ##1 fault_auto_clear_o;
	endsequence
	upd_pulse_a: assert property (run |=> table_update_o)
		else $error("no update");
	idle_quiet_a: assert property (!run |=> !table_update_o)
		else $error("stray update");
	stop_off_a: assert property (motor_state_i == `SPWM_ST_STOP |=> pwm_outputs_off_o && !pwm_enable_o)
		else $error("stop not off");
	duty_hold_a: assert property (!run && motor_state_i != 3'h0 |=> $stable(duty_a_o))
		else $error("duty moved");
	boot_start_a: assert property ($rose(fault_auto_clear_o) |-> $past(run) && pwm_enable_o)
		else $error("bad boot start");
	boot_end_a: assert property ($fell(fault_auto_clear_o) |-> boot_done_o || $past(motor_state_i) == 3'h0)
		else $error("bad boot end");
	oc_follow_a: assert property (boot_run |-> pwm_outputs_off_o == $past(overcurrent_comparator_i))
		else $error("no follow");
	oc_latch_a: assert property (boot_done_o && motor_state_i != 3'h0 && (overcurrent_comparator_i
		|| pwm_outputs_off_o) |=> pwm_outputs_off_o)
		else $error("no latch");
endmodule
bind spwm_actuator spwm_props i_spwm_props (.*);
